// *** pkg/tmr_params.svh ***
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TMR_OFF_CTRL   12'h000
`define TMR_OFF_COUNT  12'h004
`define TMR_OFF_CMPA   12'h008
`define TMR_OFF_CMPB   12'h00C
`define TMR_OFF_FLAGS  12'h010
`define TMR_OFF_FORCE  12'h014
`define TMR_OFF_PORT   12'h018
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define TMR_CTRL_CS_LSB    0
`define TMR_CTRL_WGM_LSB   4
`define TMR_CTRL_COMA_LSB  8
`define TMR_CTRL_COMB_LSB  10
`define TMR_CTRL_MASK      32'h00000F77
// ---------------------------------------------------------------
// flag bit positions
// ---------------------------------------------------------------
`define TMR_FLAG_OVF   0
`define TMR_FLAG_CMPA  1
`define TMR_FLAG_CMPB  2
// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define TMR_RST_BYTE   8'h00
`define TMR_MAX        8'hFF
`define TMR_COM_OFF    2'h0
`define TMR_COM_TOG    2'h1
`define TMR_COM_CLR    2'h2
`define TMR_COM_SET    2'h3
`define TMR_WGM_NORMAL 3'h0
`define TMR_WGM_CTC    3'h2
`endif

// *** pkg/tmr_pkg.sv ***
package tmr_pkg;
  // prescaler selections, clock select field values
  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'h0,
    TMR_CS_1    = 3'h1,
    TMR_CS_8    = 3'h2,
    TMR_CS_32   = 3'h3,
    TMR_CS_64   = 3'h4,
    TMR_CS_128  = 3'h5,
    TMR_CS_256  = 3'h6,
    TMR_CS_1024 = 3'h7
  } tmr_cs_t;
endpackage

// *** rtl/tmr_timer.sv ***
// The register offsets and the APB interface to the registers were decided locally.
`include "tmr_params.svh"
// How it works
// - force strobe applies output action like match, in normal and clear-on-match modes only
// - forced match sets no flag, no clear
// - count write blocks matches next tick
// - waveform register kept across mode change
// - output mode unbuffered, used next match
// - nonzero mode overrides port value, not direction
// - output mode zero does nothing on match
// - output mode selects set, clear, toggle
// - counting depends only on generation mode
// - normal mode counts up, wraps FF to 00
// - overflow flag set when count wraps from FF to zero
// - overflow acknowledge input clears overflow flag
// - count writable any time in normal
// - clear-on-match mode clears at compare A
// - compare A unbuffered, low value wraps first
// - compare flag A raised at each top
// - toggle mode on A toggles each match
// - prescaler divides by 1..1024
// - overflow set passing max to zero
// - compare flag set next timer tick
// - count write beats clear and count
// - writing one clears compare flag
// - stopped timer keeps count accessible
module tmr_timer #(
  parameter int PS_W = 10                 // prescaler width
) (
  input  wire logic        pclk,          // bus clock, 50 MHz
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        ovf_ack,       // overflow interrupt taken
  input  wire logic        cmpa_ack,      // compare a interrupt taken
  input  wire logic        cmpb_ack,      // compare b interrupt taken
  output logic             ovf_flag_o,    // overflow flag
  output logic             cmpa_flag_o,   // compare flag a
  output logic             cmpb_flag_o,   // compare flag b
  output logic      [1:0]  pin_out,       // waveform pins a,b
  output logic      [1:0]  pin_oe         // pin enables a,b
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  count_reg;                 // counter value
  logic [7:0]  cmp_reg [2];               // compare values a,b
  logic [2:0]  cs_reg;                    // clock select
  logic [2:0]  wgm_reg;                   // waveform generation mode
  logic [1:0]  com_reg [2];               // compare output modes
  logic [1:0]  port_reg;                  // general port values
  logic [1:0]  ddr_reg;                   // port directions
  logic [1:0]  wave_reg;                  // waveform output registers
  logic        ovf_reg;                   // overflow flag
  logic [1:0]  cmpf_reg;                  // compare match flags
  logic        block_reg;                 // blocks matches after count write
  logic [PS_W-1:0] ps_reg;                // prescaler counter
  logic        tick;                      // timer clock enable
  logic [1:0]  match;                     // comparator matches
  logic [1:0]  match_eff;                 // unblocked matches on tick
  logic [1:0]  force_act;                 // force strobes this cycle
  logic        wr, rd_ok;                 // bus strobes
  logic [7:0]  count_next;                // next counter value
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign wr = psel && penable && pwrite;  // zero wait-state write
  always_comb begin
    rd_ok = 1'b1;
    case (paddr)
      `TMR_OFF_CTRL, `TMR_OFF_COUNT, `TMR_OFF_CMPA, `TMR_OFF_CMPB,
      `TMR_OFF_FLAGS, `TMR_OFF_FORCE, `TMR_OFF_PORT: rd_ok = 1'b1;
      default: rd_ok = 1'b0;              // unmapped address
    endcase
  end
  logic wr_count;                         // cpu write of the count
  assign wr_count = wr && (paddr == `TMR_OFF_COUNT);
  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // free running divider; taps give the selectable rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_reg <= '0;
    end else begin
      ps_reg <= ps_reg + 1'b1;
    end
  end
  // tick when the low bits of the divider roll over
  always_comb begin
    case (tmr_pkg::tmr_cs_t'(cs_reg))
      tmr_pkg::TMR_CS_STOP: tick = 1'b0;  // stopped
      tmr_pkg::TMR_CS_1:    tick = 1'b1;
      tmr_pkg::TMR_CS_8:    tick = (ps_reg[2:0] == 3'h7);
      tmr_pkg::TMR_CS_32:   tick = (ps_reg[4:0] == 5'h1F);
      tmr_pkg::TMR_CS_64:   tick = (ps_reg[5:0] == 6'h3F);
      tmr_pkg::TMR_CS_128:  tick = (ps_reg[6:0] == 7'h7F);
      tmr_pkg::TMR_CS_256:  tick = (ps_reg[7:0] == 8'hFF);
      tmr_pkg::TMR_CS_1024: tick = (ps_reg[9:0] == 10'h3FF);
      default:              tick = 1'b0;
    endcase
  end
  // ---------------------------------------------------------------
  // comparator
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      assign match[g] = (count_reg == cmp_reg[g]);
      // suppressed for one timer tick after a count write
      assign match_eff[g] = match[g] && tick && !block_reg;
      // forcing only in non-pwm modes
      assign force_act[g] = wr && (paddr == `TMR_OFF_FORCE) && pwdata[g] &&
                            (wgm_reg == `TMR_WGM_NORMAL || wgm_reg == `TMR_WGM_CTC);
    end
  endgenerate
  // ---------------------------------------------------------------
  // match blocking
  // ---------------------------------------------------------------
  // set by a count write, held until the next timer tick even when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // sequence depends only on wgm, never on com
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      if (wgm_reg == `TMR_WGM_CTC && match[0]) begin
        count_next = `TMR_RST_BYTE;       // clear at top a
      end else begin
        count_next = count_reg + 8'h01;   // wraps ff to 00
      end
    end
  end
  // cpu write wins over clear and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `TMR_RST_BYTE;
    end else if (wr_count) begin
      count_reg <= pwdata[7:0];
    end else begin
      count_reg <= count_next;
    end
  end
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // com is taken live, no buffering with the compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_reg     <= 3'h0;
      wgm_reg    <= `TMR_WGM_NORMAL;
      com_reg[0] <= `TMR_COM_OFF;
      com_reg[1] <= `TMR_COM_OFF;
      cmp_reg[0] <= `TMR_RST_BYTE;
      cmp_reg[1] <= `TMR_RST_BYTE;
      port_reg   <= 2'h0;
      ddr_reg    <= 2'h0;
    end else if (wr) begin
      case (paddr)
        `TMR_OFF_CTRL: begin
          cs_reg     <= pwdata[`TMR_CTRL_CS_LSB +: 3];
          wgm_reg    <= pwdata[`TMR_CTRL_WGM_LSB +: 3];
          com_reg[0] <= pwdata[`TMR_CTRL_COMA_LSB +: 2];
          com_reg[1] <= pwdata[`TMR_CTRL_COMB_LSB +: 2];
        end
        `TMR_OFF_CMPA: cmp_reg[0] <= pwdata[7:0]; // direct, no buffer
        `TMR_OFF_CMPB: cmp_reg[1] <= pwdata[7:0];
        `TMR_OFF_PORT: begin
          port_reg <= pwdata[1:0];
          ddr_reg  <= pwdata[9:8];
        end
        default: ;                        // other offsets store nothing here
      endcase
    end
  end
  // ---------------------------------------------------------------
  // waveform output registers
  // ---------------------------------------------------------------
  // action on real or forced match; untouched by mode change
  generate
    for (g = 0; g < 2; g++) begin : g_wave
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave_reg[g] <= 1'b0;
        end else if (match_eff[g] || force_act[g]) begin
          case (com_reg[g])
            `TMR_COM_TOG: wave_reg[g] <= ~wave_reg[g];
            `TMR_COM_CLR: wave_reg[g] <= 1'b0;
            `TMR_COM_SET: wave_reg[g] <= 1'b1;
            default:      wave_reg[g] <= wave_reg[g];  // no action
          endcase
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  logic ovf_set;                          // counter passes max to zero
  assign ovf_set = tick && !wr_count && (count_reg == `TMR_MAX) &&
                   (count_next == `TMR_RST_BYTE);
  logic [1:0] cmpf_clr;                   // software or ack clears
  assign cmpf_clr[0] = (wr && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_CMPA]) ||
                       cmpa_ack;
  assign cmpf_clr[1] = (wr && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_CMPB]) ||
                       cmpb_ack;
  // set wins over clear; forced matches never reach here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpf_reg <= 2'h0;
    end else begin
      cmpf_reg <= (cmpf_reg & ~cmpf_clr) | match_eff;
    end
  end
  // hardware only sets; ack or software one clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else if (ovf_set) begin
      ovf_reg <= 1'b1;
    end else if (ovf_ack || (wr && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_OVF])) begin
      ovf_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pin value overridden when com nonzero; direction stays ddr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 2'h0;
      pin_oe  <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        pin_out[i] <= (com_reg[i] != `TMR_COM_OFF) ? wave_reg[i] : port_reg[i];
        pin_oe[i]  <= ddr_reg[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_o  <= 1'b0;
      cmpa_flag_o <= 1'b0;
      cmpb_flag_o <= 1'b0;
    end else begin
      ovf_flag_o  <= ovf_reg;
      cmpa_flag_o <= cmpf_reg[0];
      cmpb_flag_o <= cmpf_reg[1];
    end
  end
  // ---------------------------------------------------------------
  // apb read path
  // ---------------------------------------------------------------
  // ready in setup so the access phase completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `TMR_OFF_CTRL:  prdata <= {20'h00000, com_reg[1], com_reg[0], 1'b0,
                                     wgm_reg, 1'b0, cs_reg};
          `TMR_OFF_COUNT: prdata <= {24'h000000, count_reg};
          `TMR_OFF_CMPA:  prdata <= {24'h000000, cmp_reg[0]};
          `TMR_OFF_CMPB:  prdata <= {24'h000000, cmp_reg[1]};
          `TMR_OFF_FLAGS: prdata <= {29'h00000000, cmpf_reg, ovf_reg};
          `TMR_OFF_PORT:  prdata <= {22'h000000, ddr_reg, 6'h00, wave_reg};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // checker helper, decoded straight from the bus pins so that it does not
  // lean on the blocking flag it is meant to watch
  logic chk_wr_pend;                      // count write waiting for its first tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_wr_pend <= 1'b0;
    end else if (psel && penable && pwrite && (paddr == `TMR_OFF_COUNT)) begin
      chk_wr_pend <= 1'b1;                // armed by any count write
    end else if (tick) begin
      chk_wr_pend <= 1'b0;                // first tick after the write consumed
    end
  end
  property p_block;
    @(posedge pclk) disable iff (!presetn)
      (chk_wr_pend && tick) |-> (match_eff == 2'b00);
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  property p_force_noflag;
    @(posedge pclk) disable iff (!presetn)
      (force_act[0] && !match_eff[0] && !cmpf_reg[0]) |=> !cmpf_reg[0];
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set flag");
  property p_ctc_clear;
    @(posedge pclk) disable iff (!presetn)
      (tick && !wr_count && wgm_reg == `TMR_WGM_CTC && match[0]) |=> count_reg == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc no clear");
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (tick && !wr_count && count_reg == 8'hFF && wgm_reg == `TMR_WGM_NORMAL)
      |=> (count_reg == 8'h00 && ovf_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong");
  property p_cwrite;
    @(posedge pclk) disable iff (!presetn)
      wr_count |=> count_reg == $past(pwdata[7:0]);
  endproperty
  a_cwrite: assert property (p_cwrite) else $error("count write lost");
  property p_flag_next;
    @(posedge pclk) disable iff (!presetn)
      match_eff[0] |=> cmpf_reg[0];
  endproperty
  a_flag_next: assert property (p_flag_next) else $error("flag not set");
  property p_com0;
    @(posedge pclk) disable iff (!presetn)
      (com_reg[0] == `TMR_COM_OFF) |=> $stable(wave_reg[0]);
  endproperty
  a_com0: assert property (p_com0) else $error("wave changed at mode 0");
  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
      (match_eff[0] && com_reg[0] == `TMR_COM_TOG) |=> wave_reg[0] != $past(wave_reg[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_pin;
    @(posedge pclk) disable iff (!presetn)
      (com_reg[0] != `TMR_COM_OFF) ##1 (com_reg[0] != `TMR_COM_OFF)
      |-> pin_out[0] == $past(wave_reg[0]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not overridden");
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (cs_reg == 3'h0 && !wr_count) |=> $stable(count_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  // overflow flag only ever cleared by acknowledge or a software one
  property p_ovf_keep;
    @(posedge pclk) disable iff (!presetn)
      (ovf_reg && !ovf_ack && !(wr && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_OVF]))
      |=> ovf_reg;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
  // writing one to compare flag a clears it unless a match sets it again
  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `TMR_OFF_FLAGS && pwdata[`TMR_FLAG_CMPA] && !match_eff[0])
      |=> !cmpf_reg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");
  // pin direction follows the direction bits whatever the output mode
  property p_dir;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_oe == $past(ddr_reg);
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction not from port");
endmodule

// *** tb/tmr_timer_tb.sv ***
`include "tmr_params.svh"
module tmr_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic        pclk = 1'b0;     // bus clock
  logic        presetn = 1'b0;  // async reset
  logic        psel = 1'b0;     // apb select
  logic        penable = 1'b0;  // apb access
  logic        pwrite = 1'b0;   // apb direction
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0;  // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  logic        ovf_ack = 1'b0;  // overflow taken
  logic        cmpa_ack = 1'b0; // compare a taken
  logic        cmpb_ack = 1'b0; // compare b taken
  logic        ovf_flag_o;      // overflow flag
  logic        cmpa_flag_o;     // compare flag a
  logic        cmpb_flag_o;     // compare flag b
  logic [1:0]  pin_out;         // waveform pins
  logic [1:0]  pin_oe;          // pin enables
  int          n_mismatch = 0;  // mismatches
  int          compares = 0;    // comparisons
  int          cyc = 0;         // cycle count for the hang limit
  logic [31:0] rv;              // last read value
  logic        err;             // last slave error

  tmr_timer #(.PS_W(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack),
    .cmpb_ack(cmpb_ack), .ovf_flag_o(ovf_flag_o), .cmpa_flag_o(cmpa_flag_o),
    .cmpb_flag_o(cmpb_flag_o), .pin_out(pin_out), .pin_oe(pin_oe));

  always #10 pclk = ~pclk;

  // hang limit: the longest run is the prescaler sweep, about 25k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // run the counter at a given select for n bus cycles, then stop it
  task automatic run(input logic [31:0] ctl, input int n);
    wr(`TMR_OFF_CTRL, ctl);
    repeat (n) @(posedge pclk);
    wr(`TMR_OFF_CTRL, ctl & 32'hFFFFFFF8);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] a[6] = '{`TMR_OFF_CTRL, `TMR_OFF_COUNT, `TMR_OFF_CMPA, `TMR_OFF_CMPB,
                          `TMR_OFF_FLAGS, `TMR_OFF_PORT};
    foreach (a[i]) begin
      rd(a[i]);
      chk(rv, 32'h0, "reset value");
    end
    chk({pin_out, pin_oe, ovf_flag_o, cmpa_flag_o, cmpb_flag_o}, 32'h0, "reset pins");
    rd(12'h01C);
    chk(err, 1'b1, "unmapped read error");
    chk(rv, 32'h0, "unmapped read data");
    wr(`TMR_OFF_COUNT, 32'hA5);
    rd(`TMR_OFF_COUNT);
    chk(rv, 32'hA5, "stopped count access");
    wr(`TMR_OFF_COUNT, 32'h0);
  endtask

  // force strobe under every output mode, then mode change and pin override
  task automatic t_force();
    logic [1:0] cm[4] = '{`TMR_COM_SET, `TMR_COM_CLR, `TMR_COM_TOG, `TMR_COM_OFF};
    logic       ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(`TMR_OFF_PORT, 32'h300);
    foreach (cm[i]) begin
      wr(`TMR_OFF_CTRL, {22'h0, cm[i], 8'h00});
      wr(`TMR_OFF_FORCE, 32'h1);
      rd(`TMR_OFF_PORT);
      chk(rv[0], ex[i], "forced output");
      rd(`TMR_OFF_FLAGS);
      chk(rv[2:0], 3'h0, "forced flag");
      rd(`TMR_OFF_COUNT);
      chk(rv, 32'h0, "forced count");
    end
    repeat (2) @(posedge pclk);
    chk(pin_out, 2'b00, "port value with mode zero");
    wr(`TMR_OFF_CTRL, {22'h0, `TMR_COM_TOG, 1'b0, `TMR_WGM_CTC, 4'h0});
    rd(`TMR_OFF_PORT);
    chk(rv[0], 1'b1, "kept over mode change");
    wr(`TMR_OFF_PORT, 32'h302);
    repeat (2) @(posedge pclk);
    chk({pin_oe, pin_out}, 4'b1111, "override and direction");
  endtask

  // normal mode wrap, overflow and compare b, then flag clears by acknowledge
  task automatic t_normal();
    wr(`TMR_OFF_CTRL, 32'h0);
    wr(`TMR_OFF_CMPA, 32'h80);
    wr(`TMR_OFF_CMPB, 32'hFE);
    wr(`TMR_OFF_COUNT, 32'hFC);
    run(32'(tmr_pkg::TMR_CS_1), 10);
    rd(`TMR_OFF_COUNT);
    chk(rv[7:0] > 8'h02 && rv[7:0] < 8'h10, 1'b1, "normal wrap");
    chk(ovf_flag_o, 1'b1, "overflow flag out");
    chk(cmpb_flag_o, 1'b1, "compare b flag out");
    rd(`TMR_OFF_FLAGS);
    chk(rv[2:0], 3'b101, "normal flags");
    @(posedge pclk);
    ovf_ack <= 1'b1;
    cmpb_ack <= 1'b1;
    @(posedge pclk);
    ovf_ack <= 1'b0;
    cmpb_ack <= 1'b0;
    rd(`TMR_OFF_FLAGS);
    chk(rv[2:0], 3'b000, "acknowledge clears");
  endtask

  // clear on match with toggle output, then a top below the count
  task automatic t_ctc();
    logic [31:0] ctl;
    int          tg;
    logic        p;
    ctl = {22'h0, `TMR_COM_TOG, 1'b0, `TMR_WGM_CTC, 1'b0, tmr_pkg::TMR_CS_1};
    wr(`TMR_OFF_CMPA, 32'h3);
    wr(`TMR_OFF_CTRL, ctl & 32'hFFFFFFF8);
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_CTRL, ctl);
    tg = 0;
    p = pin_out[0];
    repeat (40) begin
      @(posedge pclk);
      if (pin_out[0] !== p) tg++;
      p = pin_out[0];
    end
    chk(tg >= 9 && tg <= 11, 1'b1, "toggle rate");
    wr(`TMR_OFF_CTRL, ctl & 32'hFFFFFFF8);
    rd(`TMR_OFF_COUNT);
    chk(rv[7:0] <= 8'h03, 1'b1, "count bounded by top");
    rd(`TMR_OFF_FLAGS);
    chk(rv[1:0], 2'b10, "top flag");
    chk(cmpa_flag_o, 1'b1, "compare a flag out");
    wr(`TMR_OFF_FLAGS, 32'h2);
    rd(`TMR_OFF_FLAGS);
    chk(rv[1], 1'b0, "write one clears");
    wr(`TMR_OFF_COUNT, 32'h50);
    run(ctl, 100);
    rd(`TMR_OFF_COUNT);
    chk(rv[7:0] > 8'h50, 1'b1, "missed top runs on");
    rd(`TMR_OFF_FLAGS);
    chk(rv[1:0], 2'b00, "no match before wrap");
    run(ctl, 200);
    rd(`TMR_OFF_FLAGS);
    chk(rv[1:0], 2'b11, "wrap then match");
    wr(`TMR_OFF_FLAGS, 32'h7);
  endtask

  // count write blocks the match on the next tick; write beats counting
  task automatic t_block();
    wr(`TMR_OFF_CTRL, 32'h0);
    wr(`TMR_OFF_CMPA, 32'h20);
    wr(`TMR_OFF_COUNT, 32'h20);
    run(32'(tmr_pkg::TMR_CS_1), 5);
    rd(`TMR_OFF_FLAGS);
    chk(rv[1], 1'b0, "match blocked");
    wr(`TMR_OFF_CTRL, 32'(tmr_pkg::TMR_CS_1));
    wr(`TMR_OFF_COUNT, 32'h90);
    wr(`TMR_OFF_CTRL, 32'h0);
    rd(`TMR_OFF_COUNT);
    chk(rv[7:0] >= 8'h90 && rv[7:0] <= 8'h94, 1'b1, "write wins");
  endtask

  // every prescaler division over sixteen ticks
  task automatic t_presc();
    int dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
    foreach (dv[i]) begin
      wr(`TMR_OFF_COUNT, 32'h0);
      run(32'(i + 1), 16 * dv[i]);
      rd(`TMR_OFF_COUNT);
      chk(rv[7:0] >= 8'd15 && rv[7:0] <= 8'd19, 1'b1, "prescaler rate");
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_force();
    t_normal();
    t_ctc();
    t_block();
    t_presc();
    stop_test();
  end
endmodule
